// File: hw/eat_consts.svh
`ifndef EAT_CONSTS_SVH
`define EAT_CONSTS_SVH
// Register byte offsets
`define EAT_OFS_CTRL     8'h00
`define EAT_OFS_TPT      8'h04
`define EAT_OFS_PRESC    8'h08
`define EAT_OFS_CAM_LO   8'h0C
`define EAT_OFS_CAM_HI   8'h10
`define EAT_OFS_ANG_CYC  8'h14
`define EAT_OFS_STATUS   8'h18
`define EAT_OFS_INT_STAT 8'h1C
`define EAT_OFS_INT_MASK 8'h20
`define EAT_OFS_TRR      8'h24
`define EAT_OFS_PERIOD   8'h28
`define EAT_OFS_ANGLE    8'h2C
// Control fields
`define EAT_CTRL_EN      0
`define EAT_CTRL_CRK_POL 1
`define EAT_CTRL_CAM_POL 2
`define EAT_CTRL_MISS_LO 4
`define EAT_CTRL_MISS_HI 5
`define EAT_CTRL_TEETH_LO 8
`define EAT_CTRL_TEETH_HI 15
// Interrupt status bits
`define EAT_INT_SYNC_CHG 0
`define EAT_INT_CAM_LOST 1
`define EAT_INT_TRR_OVF  2
// Reset values
`define EAT_RST_CTRL     32'h0000_2220
`define EAT_RST_TPT      10'h00A
`define EAT_RST_PRESC    8'h00
`define EAT_RST_ANG_CYC  24'h00_02D0
// Tick rate arithmetic
`define EAT_TRR_PRE_SHIFT  3
`define EAT_TRR_POST_SHIFT 6
`define EAT_TRR_LIMIT      24'hFF_FFFF
`define EAT_ONE_Q15        24'h00_8000
`endif

// File: hw/eat_pkg.sv
package eat_pkg;
   typedef enum logic [2:0] {
      EAT_SYNC_NONE = 3'b001,
      EAT_SYNC_HALF = 3'b010,
      EAT_SYNC_FULL = 3'b100
   } eat_sync_t;
   typedef enum logic [2:0] {
      EAT_CAM_SEEK  = 3'b001,
      EAT_CAM_ANGLE = 3'b010,
      EAT_CAM_LOST  = 3'b100
   } eat_cam_t;
   typedef enum logic [2:0] {
      EAT_CRK_SEEK = 3'b001,
      EAT_CRK_MEAS = 3'b010,
      EAT_CRK_SYNC = 3'b100
   } eat_crk_t;
endpackage

// File: hw/eat_trr_div.sv
`timescale 1ns/1ps
`default_nettype none
`include "eat_consts.svh"
module eat_trr_div #(
   parameter int TB_W = 24,
   parameter int TPT_W = 10
) (
   input  wire logic             clk_in,
   input  wire logic             rst_b_in,
   input  wire logic             start_in,
   input  wire logic [TB_W-1:0]  period_in,
   input  wire logic [TPT_W-1:0] tpt_in,
   output logic                  done_out,
   output logic                  ovf_out,
   output logic [TB_W-1:0]       trr_out
);
   logic [TB_W-1:0]  num_q;
   logic [TB_W-1:0]  quo_q;
   logic [TPT_W:0]   rem_q;
   logic [TPT_W-1:0] div_q;
   logic [5:0]       cnt_q;
   logic             busy_q;
   logic             pre_ovf_q;
   logic [TPT_W:0]   rem_sh;
   logic             take;

   assign rem_sh = {rem_q[TPT_W-1:0], num_q[TB_W-1]};
   assign take   = rem_sh >= {1'b0, div_q};

   // Restoring division, one quotient bit per cycle; period is shifted left 3 first
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         busy_q    <= 1'b0;
         done_out  <= 1'b0;
         ovf_out   <= 1'b0;
         trr_out   <= '0;
         num_q     <= '0;
         quo_q     <= '0;
         rem_q     <= '0;
         div_q     <= '0;
         cnt_q     <= '0;
         pre_ovf_q <= 1'b0;
      end else begin
         done_out <= 1'b0;
         if (start_in && !busy_q) begin
            busy_q    <= 1'b1;
            num_q     <= period_in << `EAT_TRR_PRE_SHIFT;
            pre_ovf_q <= |period_in[TB_W-1:TB_W-`EAT_TRR_PRE_SHIFT];
            div_q     <= (tpt_in == '0) ? TPT_W'(1) : tpt_in;
            quo_q     <= '0;
            rem_q     <= '0;
            cnt_q     <= 6'(TB_W);
         end else if (busy_q) begin
            num_q <= num_q << 1;
            quo_q <= {quo_q[TB_W-2:0], take};
            rem_q <= take ? rem_sh - {1'b0, div_q} : rem_sh;
            cnt_q <= cnt_q - 6'h01;
            if (cnt_q == 6'h01) begin
               busy_q   <= 1'b0;
               done_out <= 1'b1;
               // Result is 15.9 unsigned fixed point
               trr_out  <= {quo_q[TB_W-2-`EAT_TRR_POST_SHIFT:0], take,
                            {`EAT_TRR_POST_SHIFT{1'b0}}};
               ovf_out  <= pre_ovf_q |
                           (|quo_q[TB_W-2:TB_W-1-`EAT_TRR_POST_SHIFT]);
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: hw/eat_cam_trk.sv
`timescale 1ns/1ps
`default_nettype none
module eat_cam_trk #(
   parameter int ANG_W = 24
) (
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   input  wire logic              clear_in,
   input  wire logic              cam_edge_in,
   input  wire logic              cycle_wrap_in,
   input  wire logic [ANG_W-1:0]  angle_in,
   input  wire logic [ANG_W-1:0]  win_lo_in,
   input  wire logic [ANG_W-1:0]  win_hi_in,
   output eat_pkg::eat_cam_t      status_out,
   output logic                   found_out,
   output logic                   link_req_out
);
   import eat_pkg::*;
   logic seen_q;
   logic in_win;

   assign in_win = (angle_in >= win_lo_in) && (angle_in <= win_hi_in);

   // Single lobe: only the first active edge of an engine cycle counts
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         seen_q <= 1'b0;
      end else if (clear_in || cycle_wrap_in) begin
         seen_q <= 1'b0;
      end else if (cam_edge_in) begin
         seen_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         status_out   <= EAT_CAM_SEEK;
         found_out    <= 1'b0;
         link_req_out <= 1'b0;
      end else begin
         found_out    <= 1'b0;
         link_req_out <= 1'b0;
         if (clear_in) begin
            status_out <= EAT_CAM_SEEK;
         end else if (cam_edge_in && !seen_q) begin
            if (in_win) begin
               status_out <= EAT_CAM_ANGLE;
               found_out  <= 1'b1;
            end else if (status_out == EAT_CAM_ANGLE) begin
               status_out   <= EAT_CAM_LOST;
               link_req_out <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: hw/eat_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "eat_consts.svh"
module eat_top #(
   parameter int TB_W  = 24,
   parameter int TPT_W = 10
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_b_in,
   // Sensors
   input  wire logic             crank_in,
   input  wire logic             cam_in,
   // Register port
   input  wire logic [7:0]       addr_in,
   input  wire logic [31:0]      wr_data_in,
   input  wire logic             wr_en_in,
   input  wire logic             rd_en_in,
   output logic [31:0]           rd_data_out,
   // Status
   output logic                  irq_out,
   output logic [TB_W-1:0]       angle_counter_out,
   output eat_pkg::eat_sync_t    sync_status_out
);
   import eat_pkg::*;

   logic              rst_s1_q;
   logic              rst_n;
   logic [31:0]       ctrl_q;
   logic [TPT_W-1:0]  tpt_q;
   logic [7:0]        presc_q;
   logic [7:0]        presc_cnt_q;
   logic [TB_W-1:0]   cam_lo_q;
   logic [TB_W-1:0]   cam_hi_q;
   logic [TB_W-1:0]   ang_cyc_q;
   logic [2:0]        int_stat_q;
   logic [2:0]        int_mask_q;
   logic              tb_tick_q;
   logic [TB_W-1:0]   time_base_counter_q;
   logic [TB_W-1:0]   last_edge_q;
   logic [TB_W-1:0]   period_q;
   logic [TB_W-1:0]   prev_period_q;
   logic              crank_prev_q;
   logic              cam_prev_q;
   eat_crk_t          crk_q;
   logic [7:0]        tooth_q;
   logic [TB_W-1:0]   angle_base_q;
   logic [TB_W-1:0]   acc_q;
   logic [TPT_W-1:0]  sub_q;
   logic              wrap_q;
   logic              en;
   logic              crank_edge;
   logic              cam_edge;
   logic [TB_W-1:0]   period_d;
   logic              gap;
   logic              gap_due;
   logic [2:0]        miss_cnt;
   logic [TB_W-1:0]   step;
   logic [TB_W-1:0]   base_next;
   logic [TB_W-1:0]   trr;
   logic              trr_done;
   logic              trr_ovf;
   eat_cam_t          cam_status;
   logic              cam_found;
   logic              cam_link;
   eat_sync_t         sync_d;
   logic [2:0]        int_set;

   // Reset release through two flops
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rst_s1_q <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n    <= rst_s1_q;
      end
   end

   assign en         = ctrl_q[`EAT_CTRL_EN];
   assign crank_edge = en && (crank_in != crank_prev_q) && (crank_in == ctrl_q[`EAT_CTRL_CRK_POL]);
   assign cam_edge   = en && (cam_in != cam_prev_q) && (cam_in == ctrl_q[`EAT_CTRL_CAM_POL]);
   assign period_d   = time_base_counter_q - last_edge_q;
   // A gap spans more than twice the previous tooth period
   assign gap        = (period_d > {prev_period_q[TB_W-2:0], 1'b0});
   assign gap_due    = (tooth_q == ctrl_q[`EAT_CTRL_TEETH_HI:`EAT_CTRL_TEETH_LO] - 8'h01);
   assign miss_cnt   = {1'b0, ctrl_q[`EAT_CTRL_MISS_HI:`EAT_CTRL_MISS_LO]} + 3'h1;
   assign step       = gap ? TB_W'(tpt_q) * TB_W'(miss_cnt) : TB_W'(tpt_q);

   always_comb begin
      base_next = angle_base_q + step;
      if (base_next >= ang_cyc_q) begin
         base_next = base_next - ang_cyc_q;
      end
   end

   // Register writes
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q     <= `EAT_RST_CTRL;
         tpt_q      <= `EAT_RST_TPT;
         presc_q    <= `EAT_RST_PRESC;
         cam_lo_q   <= '0;
         cam_hi_q   <= '0;
         ang_cyc_q  <= `EAT_RST_ANG_CYC;
         int_mask_q <= '0;
      end else if (wr_en_in) begin
         case (addr_in)
            `EAT_OFS_CTRL:     ctrl_q     <= wr_data_in;
            `EAT_OFS_TPT:      tpt_q      <= wr_data_in[TPT_W-1:0];
            `EAT_OFS_PRESC:    presc_q    <= wr_data_in[7:0];
            `EAT_OFS_CAM_LO:   cam_lo_q   <= wr_data_in[TB_W-1:0];
            `EAT_OFS_CAM_HI:   cam_hi_q   <= wr_data_in[TB_W-1:0];
            `EAT_OFS_ANG_CYC:  ang_cyc_q  <= wr_data_in[TB_W-1:0];
            `EAT_OFS_INT_MASK: int_mask_q <= wr_data_in[2:0];
            default: ;
         endcase
      end
   end

   // Time base: one-cycle enable from the prescaler
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         presc_cnt_q         <= '0;
         tb_tick_q           <= 1'b0;
         time_base_counter_q <= '0;
      end else begin
         tb_tick_q <= en && (presc_cnt_q == presc_q);
         if (!en || presc_cnt_q == presc_q) begin
            presc_cnt_q <= '0;
         end else begin
            presc_cnt_q <= presc_cnt_q + 8'h01;
         end
         if (tb_tick_q) begin
            time_base_counter_q <= time_base_counter_q + TB_W'(1);
         end
      end
   end

   // Crank tooth tracking
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         crank_prev_q  <= 1'b0;
         cam_prev_q    <= 1'b0;
         crk_q         <= EAT_CRK_SEEK;
         tooth_q       <= '0;
         last_edge_q   <= '0;
         period_q      <= '0;
         prev_period_q <= '0;
      end else begin
         crank_prev_q <= crank_in;
         cam_prev_q   <= cam_in;
         if (!en) begin
            crk_q <= EAT_CRK_SEEK;
         end else if (crank_edge) begin
            last_edge_q   <= time_base_counter_q;
            period_q      <= period_d;
            prev_period_q <= period_d;
            case (crk_q)
               EAT_CRK_SEEK: begin
                  // First edge has no tooth before it to measure
                  crk_q         <= EAT_CRK_MEAS;
                  prev_period_q <= '0;
               end
               EAT_CRK_MEAS: begin
                  tooth_q <= '0;
                  if (gap && prev_period_q != '0) begin
                     crk_q <= EAT_CRK_SYNC;
                  end
               end
               EAT_CRK_SYNC: begin
                  // One contiguous gap: it must fall exactly where expected
                  if (gap != gap_due) begin
                     crk_q <= EAT_CRK_SEEK;
                  end
                  tooth_q <= gap ? 8'h00 : tooth_q + 8'h01;
               end
               default: crk_q <= EAT_CRK_SEEK;
            endcase
         end
      end
   end

   // Tick rate, recomputed from the latest period on each tooth edge outside the seek state
   eat_trr_div #(
      .TB_W  (TB_W),
      .TPT_W (TPT_W)
   ) u_div (
      .clk_in    (clk_in),
      .rst_b_in  (rst_n),
      .start_in  (crank_edge && crk_q != EAT_CRK_SEEK),
      .period_in (period_d),
      .tpt_in    (tpt_q),
      .done_out  (trr_done),
      .ovf_out   (trr_ovf),
      .trr_out   (trr)
   );

   // Angle counter: trr time-base counts per step, capped within a tooth
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         angle_counter_out <= '0;
         angle_base_q      <= '0;
         acc_q             <= '0;
         sub_q             <= '0;
         wrap_q            <= 1'b0;
      end else begin
         wrap_q <= 1'b0;
         if (crank_edge) begin
            acc_q <= '0;
            sub_q <= '0;
            if (crk_q == EAT_CRK_SYNC && gap == gap_due) begin
               angle_base_q      <= base_next;
               angle_counter_out <= base_next;
               wrap_q            <= (base_next < angle_base_q);
            end else begin
               // Not yet synchronised: reset each tooth
               angle_base_q      <= '0;
               angle_counter_out <= '0;
            end
         end else if (tb_tick_q && crk_q == EAT_CRK_SYNC && trr != '0 && sub_q < tpt_q) begin
            if (acc_q + `EAT_ONE_Q15 >= trr) begin
               acc_q             <= acc_q + `EAT_ONE_Q15 - trr;
               sub_q             <= sub_q + TPT_W'(1);
               angle_counter_out <= angle_counter_out + TB_W'(1);
            end else begin
               acc_q <= acc_q + `EAT_ONE_Q15;
            end
         end
      end
   end

   eat_cam_trk #(
      .ANG_W (TB_W)
   ) u_cam (
      .clk_in        (clk_in),
      .rst_n_in      (rst_n),
      .clear_in      (crk_q != EAT_CRK_SYNC),
      .cam_edge_in   (cam_edge),
      .cycle_wrap_in (wrap_q),
      .angle_in      (angle_counter_out),
      .win_lo_in     (cam_lo_q),
      .win_hi_in     (cam_hi_q),
      .status_out    (cam_status),
      .found_out     (cam_found),
      .link_req_out  (cam_link)
   );

   // Overall position status; single global copy, hence one instance
   always_comb begin
      sync_d = sync_status_out;
      if (crk_q != EAT_CRK_SYNC) begin
         sync_d = EAT_SYNC_NONE;
      end else if (cam_link) begin
         if (sync_status_out == EAT_SYNC_FULL) begin
            sync_d = EAT_SYNC_HALF;
         end
      end else if (cam_found) begin
         sync_d = EAT_SYNC_FULL;
      end else if (sync_status_out == EAT_SYNC_NONE) begin
         sync_d = EAT_SYNC_HALF;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         sync_status_out <= EAT_SYNC_NONE;
      end else begin
         sync_status_out <= sync_d;
      end
   end

   assign int_set[`EAT_INT_SYNC_CHG] = (sync_d != sync_status_out);
   assign int_set[`EAT_INT_CAM_LOST] = cam_link;
   assign int_set[`EAT_INT_TRR_OVF]  = trr_done && trr_ovf;

   // Sticky status, write one to clear; a new event wins
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         int_stat_q <= '0;
         irq_out    <= 1'b0;
      end else begin
         if (wr_en_in && addr_in == `EAT_OFS_INT_STAT) begin
            int_stat_q <= (int_stat_q & ~wr_data_in[2:0]) | int_set;
         end else begin
            int_stat_q <= int_stat_q | int_set;
         end
         irq_out <= |(int_stat_q & int_mask_q);
      end
   end

   // Read data in the cycle after the strobe, zero otherwise
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_out <= '0;
      end else if (rd_en_in) begin
         case (addr_in)
            `EAT_OFS_CTRL:     rd_data_out <= ctrl_q;
            `EAT_OFS_TPT:      rd_data_out <= 32'(tpt_q);
            `EAT_OFS_PRESC:    rd_data_out <= 32'(presc_q);
            `EAT_OFS_CAM_LO:   rd_data_out <= 32'(cam_lo_q);
            `EAT_OFS_CAM_HI:   rd_data_out <= 32'(cam_hi_q);
            `EAT_OFS_ANG_CYC:  rd_data_out <= 32'(ang_cyc_q);
            `EAT_OFS_STATUS:   rd_data_out <= {8'h00, tooth_q, 7'h00, crk_q,
                                               cam_status, sync_status_out};
            `EAT_OFS_INT_STAT: rd_data_out <= 32'(int_stat_q);
            `EAT_OFS_INT_MASK: rd_data_out <= 32'(int_mask_q);
            `EAT_OFS_TRR:      rd_data_out <= 32'(trr);
            `EAT_OFS_PERIOD:   rd_data_out <= 32'(period_q);
            `EAT_OFS_ANGLE:    rd_data_out <= 32'(angle_counter_out);
            default:           rd_data_out <= '0;
         endcase
      end else begin
         rd_data_out <= '0;
      end
   end
endmodule
`default_nettype wire

// File: testbench/eat_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "eat_consts.svh"
module eat_checker
   import eat_pkg::*;
#(
   parameter int TB_W  = 24,
   parameter int TPT_W = 10
) (
   // Clock and reset
   input wire logic              clk_in,
   input wire logic              rst_b_in,
   // Sensors and register port
   input wire logic              crank_in,
   input wire logic              cam_in,
   input wire logic [7:0]        addr_in,
   input wire logic [31:0]       wr_data_in,
   input wire logic              wr_en_in,
   input wire logic              rd_en_in,
   input wire logic [31:0]       rd_data_out,
   // Status
   input wire logic              irq_out,
   input wire logic [TB_W-1:0]   angle_counter_out,
   input var  eat_pkg::eat_sync_t sync_status_out
);
   logic [2:0]      mask_q;
   logic [TB_W-1:0] cyc_q;
   logic [3:0]      cam_age_q;
   logic [3:0]      crk_age_q;

   // Shadow of what software wrote, seen from the bus
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         mask_q <= 3'h0;
         cyc_q  <= TB_W'(`EAT_RST_ANG_CYC);
      end else if (wr_en_in) begin
         if (addr_in == `EAT_OFS_INT_MASK) begin
            mask_q <= wr_data_in[2:0];
         end
         if (addr_in == `EAT_OFS_ANG_CYC) begin
            cyc_q <= wr_data_in[TB_W-1:0];
         end
      end
   end

   // Saturating ages of the sensor lines, so causes can be bounded
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cam_age_q <= 4'hF;
         crk_age_q <= 4'hF;
      end else begin
         cam_age_q <= $changed(cam_in) ? 4'h0 : 4'(cam_age_q + (cam_age_q != 4'hF));
         crk_age_q <= $changed(crank_in) ? 4'h0 : 4'(crk_age_q + (crk_age_q != 4'hF));
      end
   end

   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);

   sync_code_a: assert property (
      sync_status_out inside {EAT_SYNC_NONE, EAT_SYNC_HALF, EAT_SYNC_FULL})
      else $error("sync status code illegal");
   full_by_cam_a: assert property (
      sync_status_out == EAT_SYNC_FULL && $past(sync_status_out) != EAT_SYNC_FULL
      |-> cam_age_q <= 4'h6) else $error("full sync without cam edge");
   half_by_loss_a: assert property (
      $past(sync_status_out) == EAT_SYNC_FULL && sync_status_out == EAT_SYNC_HALF
      |-> cam_age_q <= 4'h8) else $error("full to half without cam edge");
   irq_follow_a: assert property (
      $changed(sync_status_out) && mask_q[0] |-> ##[0:3] irq_out)
      else $error("no interrupt on sync change");
   irq_masked_a: assert property (
      (mask_q == 3'h0)[*3] |-> !irq_out) else $error("interrupt while masked");
   rd_idle_a: assert property (
      !$past(rd_en_in) |-> rd_data_out == 32'h0) else $error("read data without read");
   status_read_a: assert property (
      $past(rd_en_in) && $past(addr_in) == `EAT_OFS_STATUS
      |-> rd_data_out[2:0] == $past(sync_status_out)) else $error("status read mismatch");
   trr_format_a: assert property (
      $past(rd_en_in) && $past(addr_in) == `EAT_OFS_TRR |-> rd_data_out[31:24] == 8'h00)
      else $error("tick rate wider than 24 bits");
   angle_range_a: assert property (
      angle_counter_out < cyc_q) else $error("angle beyond engine cycle");
   angle_step_a: assert property (
      $changed(angle_counter_out) && crk_age_q > 4'h5
      |-> angle_counter_out == $past(angle_counter_out) + 1) else $error("angle jump");
endmodule

bind eat_top eat_checker #(.TB_W(TB_W), .TPT_W(TPT_W)) i_chk (
   .clk_in(clk_in), .rst_b_in(rst_b_in), .crank_in(crank_in), .cam_in(cam_in),
   .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
   .rd_data_out(rd_data_out), .irq_out(irq_out), .angle_counter_out(angle_counter_out),
   .sync_status_out(sync_status_out));
`default_nettype wire

// File: testbench/eat_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
module eat_sensor_model (
   // Clock
   input  wire logic clk_in,
   // Sensor lines
   output var logic  crank_out,
   output var logic  cam_out
);
   initial begin
      crank_out = 1'b0;
      cam_out   = 1'b0;
   end

   // One tooth of d clocks; single lobe cam pulse only when asked
   task automatic tooth(input int d, input bit cam);
      @(posedge clk_in);
      crank_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      crank_out <= 1'b0;
      cam_out   <= cam;
      repeat (4) @(posedge clk_in);
      cam_out <= 1'b0;
      repeat (d - 9) @(posedge clk_in);
   endtask
endmodule
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "eat_consts.svh"
module testbench;
   import eat_pkg::*;
   logic        clk_in;
   logic        rst_b_in;
   logic [7:0]  addr_in;
   logic [31:0] wr_data_in;
   logic        wr_en_in;
   logic        rd_en_in;
   logic [31:0] rd_data_out;
   logic        irq_out;
   logic [23:0] angle_counter_out;
   eat_sync_t   sync_status_out;
   wire logic   crank_w;
   wire logic   cam_w;
   int          errors;
   int          total_checks;
   int          ang_e;
   bit          chk_on;

   eat_top i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .crank_in(crank_w), .cam_in(cam_w),
      .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
      .rd_data_out(rd_data_out), .irq_out(irq_out), .angle_counter_out(angle_counter_out),
      .sync_status_out(sync_status_out));
   eat_sensor_model i_sens (.clk_in(clk_in), .crank_out(crank_w), .cam_out(cam_w));

   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_in    <= a;
      wr_data_in <= d;
      wr_en_in   <= 1'b1;
      @(posedge clk_in);
      wr_en_in <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_in);
      addr_in  <= a;
      rd_en_in <= 1'b1;
      @(posedge clk_in);
      rd_en_in <= 1'b0;
      #1 chk(rd_data_out, exp);
   endtask

   function automatic logic [31:0] trr_of(input int p, input int tpt);
      return 32'(((p << 3) / tpt) << 6);
   endfunction

   task automatic reset_dut();
      rst_b_in <= 1'b0;
      repeat (6) @(posedge clk_in);
      rst_b_in <= 1'b1;
      repeat (3) @(posedge clk_in);
   endtask

   // Angle looked at 1 ns after the clock edge on which the crank edge loads it, before interpolation steps can land
   task automatic tt(input int d, input bit cam, input logic [31:0] trr);
      fork
         i_sens.tooth(d, cam);
         begin
            repeat (6) @(posedge clk_in);
            #1;
            if (chk_on) chk(32'(angle_counter_out), 32'(ang_e));
            if (trr != 32'h0) begin
               repeat (25) @(posedge clk_in);
               rd(`EAT_OFS_TRR, trr);
            end
         end
      join
      ang_e = (ang_e + (d > 100 ? 12 : 4)) % 48;
   endtask

   // Four teeth then a gap of two missing teeth
   task automatic rev(input bit c0, input bit c1);
      tt(60, c0, 32'h0);
      tt(60, c1, 32'h0);
      tt(60, 1'b0, 32'h0);
      tt(180, 1'b0, 32'h0);
      #1;
   endtask

   task automatic sc_reset();
      rd(`EAT_OFS_CTRL, `EAT_RST_CTRL);
      rd(`EAT_OFS_TPT, 32'(`EAT_RST_TPT));
      rd(`EAT_OFS_ANG_CYC, 32'(`EAT_RST_ANG_CYC));
      wr(`EAT_OFS_STATUS, 32'hFFFF_FFFF);
      rd(`EAT_OFS_STATUS, 32'h0000_0049);
      rd(8'h40, 32'h0);
   endtask

   task automatic sc_cam();
      wr(`EAT_OFS_TPT, 32'h4);
      wr(`EAT_OFS_ANG_CYC, 32'h30);
      wr(`EAT_OFS_CAM_LO, 32'h18);
      wr(`EAT_OFS_CAM_HI, 32'h1B);
      wr(`EAT_OFS_INT_MASK, 32'h7);
      wr(`EAT_OFS_CTRL, 32'h0000_0421);
      rev(1'b0, 1'b0);
      chk_on = 1'b1;
      ang_e = 0;
      rev(1'b0, 1'b0);
      chk(32'(sync_status_out), 32'(EAT_SYNC_HALF));
      chk(32'(irq_out), 32'h1);
      rd(`EAT_OFS_PERIOD, 32'h3C);
      rd(`EAT_OFS_TRR, trr_of(60, 4));
      wr(`EAT_OFS_INT_STAT, 32'h7);
      // Second cam edge in the same cycle lies outside the window
      rev(1'b1, 1'b1);
      chk(32'(sync_status_out), 32'(EAT_SYNC_FULL));
      rd(`EAT_OFS_INT_STAT, 32'h1);
      wr(`EAT_OFS_INT_STAT, 32'h7);
      wr(`EAT_OFS_CAM_LO, 32'h0);
      wr(`EAT_OFS_CAM_HI, 32'h2);
      rev(1'b0, 1'b0);
      rev(1'b1, 1'b0);
      chk(32'(sync_status_out), 32'(EAT_SYNC_HALF));
      rd(`EAT_OFS_STATUS, 32'h0003_0122);
      rd(`EAT_OFS_INT_STAT, 32'h3);
      wr(`EAT_OFS_INT_STAT, 32'h1);
      rd(`EAT_OFS_INT_STAT, 32'h2);
      chk(32'(irq_out), 32'h1);
      wr(`EAT_OFS_INT_MASK, 32'h0);
      rd(`EAT_OFS_INT_STAT, 32'h2);
      chk(32'(irq_out), 32'h0);
      wr(`EAT_OFS_INT_STAT, 32'h2);
      rd(`EAT_OFS_INT_STAT, 32'h0);
      wr(`EAT_OFS_INT_MASK, 32'h7);
      wr(`EAT_OFS_CAM_HI, 32'h28);
      rev(1'b0, 1'b0);
      rev(1'b1, 1'b0);
      chk(32'(sync_status_out), 32'(EAT_SYNC_FULL));
   endtask

   task automatic sc_trr();
      tt(80, 1'b0, 32'h0);
      tt(60, 1'b0, trr_of(80, 4));
      tt(60, 1'b0, trr_of(60, 4));
      tt(180, 1'b0, 32'h0);
   endtask

   // Period of 32768 counts puts the shifted quotient one past 24 bits
   task automatic sc_ovf();
      reset_dut();
      chk_on = 1'b0;
      wr(`EAT_OFS_TPT, 32'h1);
      wr(`EAT_OFS_INT_MASK, 32'h4);
      wr(`EAT_OFS_CTRL, 32'h0000_0421);
      tt(40, 1'b0, 32'h0);
      tt(32768, 1'b0, 32'h0);
      tt(40, 1'b0, 32'h0);
      rd(`EAT_OFS_INT_STAT, 32'h5);
      chk(32'(irq_out), 32'h1);
   endtask

   task automatic tally_and_finish();
      if (errors == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      rst_b_in     = 1'b0;
      addr_in      = 8'h00;
      wr_data_in   = 32'h0;
      wr_en_in     = 1'b0;
      rd_en_in     = 1'b0;
      errors       = 0;
      total_checks = 0;
      ang_e        = 0;
      chk_on       = 1'b0;
      reset_dut();
      sc_reset();
      sc_cam();
      sc_trr();
      sc_ovf();
      tally_and_finish();
   end

   // Whole run needs about 36000 clocks
   initial begin
      repeat (50000) @(posedge clk_in);
      errors++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
